// [shared/oms_pkg.sv]
package oms_pkg;

    // register map (word offsets as byte addresses)
    localparam logic [7:0] OMS_LATCH_OFS = 8'h00;
    localparam logic [7:0] OMS_MODE_OFS = 8'h04;

    // latch register layout
    localparam int OMS_FIXED_ONE_POS = 7;
    localparam logic [3:0] OMS_RSVD_ZERO = 4'h0;
    localparam logic [2:0] OMS_PINS_RST = 3'h7;
    localparam logic [31:0] OMS_UNMAPPED_RD = 32'h0000_0000;

    // mode pin patterns
    localparam logic [2:0] OMS_PAT_M4 = 3'h4;
    localparam logic [2:0] OMS_PAT_M5 = 3'h5;
    localparam logic [2:0] OMS_PAT_M6 = 3'h6;
    localparam logic [2:0] OMS_PAT_M7 = 3'h7;

    // mode numbers reported
    localparam logic [2:0] OMS_NUM_M4 = 3'h4;
    localparam logic [2:0] OMS_NUM_M5 = 3'h5;
    localparam logic [2:0] OMS_NUM_M6 = 3'h6;
    localparam logic [2:0] OMS_NUM_M7 = 3'h7;

    typedef enum logic [1:0] {
        OMS_MODE4,
        OMS_MODE5,
        OMS_MODE6,
        OMS_MODE7
    } oms_mode_t;

    // decoded mode attributes
    typedef struct packed {
        logic [2:0] mode_num;
        logic rom_en;
        logic expanded;
        logic advanced;
        logic ext_allowed;
        logic bus16_reset;
        logic valid;
    } oms_cfg_t;

endpackage : oms_pkg

// [logic/oms_top.sv]
// Our own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps

// What this block does
// - four modes, 4 to 7, from pins
// - decode 100..111 into mode attributes
// - bit 7 reads one, write ignored
// - bits 6..3 read zero, writes ignored
// - bits 2..0 report mode pins, read-only
// - pins latched when register is read
// - reset releases the captured latch
// - mode 7 forbids external accesses
// - mode 4 bus starts 16 bits wide
// - modes 5,6 bus start 8 bits wide
module oms_top
    import oms_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // mode strap pins
    input wire logic mode_select_pin_2_i,
    input wire logic mode_select_pin_1_i,
    input wire logic mode_select_pin_0_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // decoded mode
    output oms_cfg_t cfg_o
);

    logic [2:0] pins;
    logic latched_r;
    logic [2:0] sense_r;
    logic [2:0] sense_now;
    logic req;
    logic rd_latch;
    oms_cfg_t cfg_nxt;

    assign pins = {mode_select_pin_2_i, mode_select_pin_1_i, mode_select_pin_0_i};
    // single-cycle answer; req low while ack is high so each access acks once
    assign req = cyc_i && stb_i && !ack_o;
    assign rd_latch = req && !we_i && (adr_i == OMS_LATCH_OFS);
    // live pins until captured
    assign sense_now = latched_r ? sense_r : pins;

    // capture on read, released by reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            latched_r <= 1'b0;
            sense_r <= OMS_PINS_RST;
        end else if (rd_latch) begin
            latched_r <= 1'b1;
            sense_r <= pins;
        end
    end

    // decode; pins assumed static during operation
    always_comb begin
        cfg_nxt = '0;
        cfg_nxt.advanced = 1'b1;
        cfg_nxt.valid = 1'b1;
        case (pins)
            OMS_PAT_M4: begin
                cfg_nxt.mode_num = OMS_NUM_M4;
                cfg_nxt.expanded = 1'b1;
                cfg_nxt.ext_allowed = 1'b1;
                cfg_nxt.bus16_reset = 1'b1;
            end
            OMS_PAT_M5: begin
                cfg_nxt.mode_num = OMS_NUM_M5;
                cfg_nxt.expanded = 1'b1;
                cfg_nxt.ext_allowed = 1'b1;
                cfg_nxt.bus16_reset = 1'b0;
            end
            OMS_PAT_M6: begin
                cfg_nxt.mode_num = OMS_NUM_M6;
                cfg_nxt.rom_en = 1'b1;
                cfg_nxt.expanded = 1'b1;
                cfg_nxt.ext_allowed = 1'b1;
                cfg_nxt.bus16_reset = 1'b0;
            end
            OMS_PAT_M7: begin
                cfg_nxt.mode_num = OMS_NUM_M7;
                cfg_nxt.rom_en = 1'b1;
                cfg_nxt.ext_allowed = 1'b0;
            end
            default: begin
                // patterns 0xx are not modes; flag and keep ext access off
                cfg_nxt.valid = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_o <= '0;
        end else begin
            cfg_o <= cfg_nxt;
        end
    end

    // bus answer; writes have no effect anywhere
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= '0;
        end else begin
            ack_o <= req;
            if (req && !we_i) begin
                case (adr_i)
                    OMS_LATCH_OFS: begin
                        // read returns the freshly sampled pins
                        dat_o <= {24'h00_0000, 1'b1, OMS_RSVD_ZERO, pins};
                    end
                    OMS_MODE_OFS: begin
                        dat_o <= {16'h0000, 3'h0, sense_now, 2'h0, cfg_o.mode_num,
                                  cfg_o.rom_en, cfg_o.expanded, cfg_o.ext_allowed,
                                  cfg_o.bus16_reset, cfg_o.valid};
                    end
                    default: begin
                        dat_o <= OMS_UNMAPPED_RD;
                    end
                endcase
            end else begin
                dat_o <= '0;
            end
        end
    end

    AST_ACK_ONE_CYCLE: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    AST_ACK_FOLLOWS_REQ: assert property (@(posedge clk_i) disable iff (rst_i)
        (cyc_i && stb_i && !ack_o) |=> ack_o)
        else $error("request not answered next cycle");
    AST_BIT7_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_latch |=> dat_o[OMS_FIXED_ONE_POS])
        else $error("bit 7 not read as one");
    AST_RSVD_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_latch |=> (dat_o[6:3] == OMS_RSVD_ZERO))
        else $error("reserved bits not zero");
    AST_PINS_REPORTED: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_latch |=> (dat_o[2:0] == $past(pins)))
        else $error("sense bits differ from pins");
    AST_CAPTURE: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_latch |=> (latched_r && sense_r == $past(pins)))
        else $error("pins not captured on read");
    AST_RELEASE: assert property (@(posedge clk_i)
        rst_i |=> !latched_r)
        else $error("latch not released by reset");
    AST_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        (latched_r && !rd_latch) |=> $stable(sense_r))
        else $error("captured value changed without read");
    AST_MODE7_NOEXT: assert property (@(posedge clk_i) disable iff (rst_i)
        (pins == OMS_PAT_M7) |=> (!cfg_o.ext_allowed && cfg_o.rom_en))
        else $error("mode 7 allows external access");
    AST_MODE4_BUS16: assert property (@(posedge clk_i) disable iff (rst_i)
        (pins == OMS_PAT_M4) |=> (cfg_o.bus16_reset && !cfg_o.rom_en))
        else $error("mode 4 bus not 16 bits");
    AST_MODE56_BUS8: assert property (@(posedge clk_i) disable iff (rst_i)
        (pins == OMS_PAT_M5 || pins == OMS_PAT_M6) |=> !cfg_o.bus16_reset)
        else $error("mode 5 or 6 bus not 8 bits");
    AST_MODE_NUM: assert property (@(posedge clk_i) disable iff (rst_i)
        pins[2] |=> (cfg_o.valid && cfg_o.mode_num == $past(pins)))
        else $error("mode number mismatch");

    // bus side: idle data, writes, unmapped reads
    AST_DAT_IDLE_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
        !ack_o |-> (dat_o == '0))
        else $error("read data not zero outside ack");
    AST_ACK_NEEDS_REQ: assert property (@(posedge clk_i) disable iff (rst_i)
        !req |=> !ack_o)
        else $error("ack without request");
    AST_WRITE_NO_EFFECT: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && we_i) |=> ($stable(latched_r) && $stable(sense_r)))
        else $error("write changed the latch");
    AST_WRITE_DATA_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && we_i) |=> (ack_o && dat_o == '0))
        else $error("write answered with data");
    AST_UNMAPPED_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && !we_i && adr_i != OMS_LATCH_OFS && adr_i != OMS_MODE_OFS)
        |=> (dat_o == OMS_UNMAPPED_RD))
        else $error("unmapped read not zero");
    AST_RESET_QUIET: assert property (@(posedge clk_i)
        rst_i |=> (!ack_o && cfg_o == '0))
        else $error("outputs not cleared by reset");
    AST_SENSE_LIVE: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && !we_i && adr_i == OMS_MODE_OFS && !latched_r)
        |=> (dat_o[12:10] == $past(pins)))
        else $error("sense not live before first read");

    // decode side: attributes per mode
    AST_ADVANCED: assert property (@(posedge clk_i) disable iff (rst_i)
        cfg_o.valid |-> cfg_o.advanced)
        else $error("valid mode not advanced");
    AST_ROM_OFF_M45: assert property (@(posedge clk_i) disable iff (rst_i)
        (pins == OMS_PAT_M4 || pins == OMS_PAT_M5) |=> (!cfg_o.rom_en && cfg_o.expanded))
        else $error("mode 4 or 5 attributes wrong");
    AST_M6_ROM_EXP: assert property (@(posedge clk_i) disable iff (rst_i)
        (pins == OMS_PAT_M6) |=> (cfg_o.rom_en && cfg_o.expanded && cfg_o.ext_allowed))
        else $error("mode 6 attributes wrong");
    AST_M7_SINGLE: assert property (@(posedge clk_i) disable iff (rst_i)
        (pins == OMS_PAT_M7) |=> !cfg_o.expanded)
        else $error("mode 7 not single-chip");
    AST_NOT_A_MODE: assert property (@(posedge clk_i) disable iff (rst_i)
        !pins[2] |=> (!cfg_o.valid && !cfg_o.ext_allowed && cfg_o.mode_num == '0))
        else $error("invalid pattern decoded as a mode");

    COV_LATCH_READ: cover property (@(posedge clk_i) disable iff (rst_i) rd_latch);
    COV_WRITE: cover property (@(posedge clk_i) disable iff (rst_i) req && we_i);
    COV_MODE7: cover property (@(posedge clk_i) disable iff (rst_i) pins == OMS_PAT_M7);
    COV_HELD: cover property (@(posedge clk_i) disable iff (rst_i)
        latched_r && sense_r != pins);
    COV_RESET_HELD: cover property (@(posedge clk_i) latched_r && rst_i);

endmodule : oms_top

// [testbench/oms_strap.sv]
`timescale 1ns/1ps
module oms_strap (
    // chosen strap pattern
    input wire logic [2:0] pat_i,
    // mode pins
    output logic mode_select_pin_2_o,
    output logic mode_select_pin_1_o,
    output logic mode_select_pin_0_o
);
    // straps are static wiring: only the bench moves them
    assign {mode_select_pin_2_o, mode_select_pin_1_o, mode_select_pin_0_o} = pat_i;
endmodule : oms_strap

// [testbench/operating_mode_select_tb.sv]
`timescale 1ns/1ps
module operating_mode_select_tb;
    import oms_pkg::*;
    typedef struct packed {logic [2:0] pat; logic [8:0] cfg;} oms_row_t;
    logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, p2, p1, p0;
    logic [7:0] adr_i;
    logic [31:0] dat_o, rd;
    logic [2:0] pat;
    oms_cfg_t cfg_o;
    int err_total, checked;
    oms_row_t rows [4] = '{'{3'h4, 9'h11f}, '{3'h5, 9'h15d}, '{3'h6, 9'h1bd}, '{3'h7, 9'h1e9}};
    oms_strap u_strap (.pat_i(pat), .mode_select_pin_2_o(p2), .mode_select_pin_1_o(p1),
        .mode_select_pin_0_o(p0));
    oms_top DUT (.clk_i(clk_i), .rst_i(rst_i), .mode_select_pin_2_i(p2),
        .mode_select_pin_1_i(p1), .mode_select_pin_0_i(p0), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(4'hf), .dat_i(32'hffff_ffff), .dat_o(dat_o),
        .ack_o(ack_o), .cfg_o(cfg_o));
    function automatic logic [31:0] st(input logic [2:0] s, input logic [8:0] c);
        return {19'h0, s, 2'h0, c[8:4], c[2:0]};
    endfunction : st
    function automatic logic [31:0] lt(input logic [2:0] p);
        return {24'h0, 1'b1, 4'h0, p};
    endfunction : lt
    task automatic final_report();
        if (err_total == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : final_report
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic rst();
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
    endtask : rst
    // caller sits on a rising edge; waits are bounded, never assumed
    task automatic wb(input logic w, input logic [7:0] a, output logic [31:0] d);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        d = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
        if (n >= 50) err_total++;
    endtask : wb
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    initial begin
        #2000000;
        err_total++;
        final_report();
    end
    initial begin
        {rst_i, cyc_i, stb_i, we_i, adr_i, pat, err_total, checked} = '0;
        rst();
        foreach (rows[i]) begin
            pat <= rows[i].pat;
            rst();
            @(posedge clk_i);
            cmp({23'h0, cfg_o}, {23'h0, rows[i].cfg});
            wb(1'b0, OMS_MODE_OFS, rd);
            cmp(rd, st(rows[i].pat, rows[i].cfg));
            wb(1'b1, OMS_LATCH_OFS, rd);
            cmp(rd, 32'h0000_0000);
            wb(1'b0, OMS_LATCH_OFS, rd);
            cmp(rd, lt(rows[i].pat));
        end
        // pins moved on purpose to expose the latch
        pat <= 3'h6;
        rst();
        wb(1'b0, OMS_LATCH_OFS, rd);
        pat <= 3'h4;
        repeat (2) @(posedge clk_i);
        wb(1'b1, OMS_LATCH_OFS, rd);
        cmp(rd, 32'h0000_0000);
        wb(1'b0, OMS_MODE_OFS, rd);
        cmp(rd, st(3'h6, rows[0].cfg));
        wb(1'b0, OMS_LATCH_OFS, rd);
        cmp(rd, lt(3'h4));
        pat <= 3'h5;
        repeat (2) @(posedge clk_i);
        wb(1'b0, OMS_MODE_OFS, rd);
        cmp(rd, st(3'h4, rows[1].cfg));
        rst();
        wb(1'b0, OMS_MODE_OFS, rd);
        cmp(rd, st(3'h5, rows[1].cfg));
        wb(1'b0, 8'h08, rd);
        cmp(rd, OMS_UNMAPPED_RD);
        pat <= 3'h3;
        rst();
        @(posedge clk_i);
        cmp({23'h0, cfg_o}, 32'h0000_0008);
        final_report();
    end
endmodule : operating_mode_select_tb
